//--- ecm_pkg.sv
// Constants, register map and carrier types of the event code action mapper
package ecm_pkg;

    // ************************************************************
    // Bus and register map
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_MAP_CODE = 12'h008;
    localparam logic [11:0] REG_MAP_SPC = 12'h00c;
    localparam logic [11:0] REG_MAP_TRG = 12'h010;
    localparam logic [11:0] REG_MAP_SET = 12'h014;
    localparam logic [11:0] REG_MAP_RST = 12'h018;
    localparam logic [11:0] REG_SECONDS = 12'h01c;
    localparam logic [11:0] REG_SUBSEC = 12'h020;
    localparam logic [11:0] REG_SHIFT = 12'h024;
    localparam logic [11:0] REG_LOG_IDX = 12'h028;
    localparam logic [11:0] REG_LOG_DATA = 12'h02c;
    localparam logic [11:0] REG_CONS_BASE = 12'h040;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CTRL_BUF_MODE = 0;
    localparam int CTRL_TS_MAPPED = 1;
    localparam int CTRL_LOG_CLEAR = 2;
    localparam int MAP_COMMIT_BIT = 8;
    localparam int ST_FROZEN = 0;
    localparam int ST_LOCKED = 1;
    localparam int ST_LOCK_FAULT = 2;
    localparam int ST_HB_TIMEOUT = 3;
    localparam int ST_UNSTABLE = 4;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [7:0] NO_CODE = 8'h00;
    localparam int CODE_W = 8;
    localparam int LOG_SUB_W = 24;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_NS = 4;
    localparam int HB_DIV_NS = 1000;
    localparam int HB_DIV_CYCLES = HB_DIV_NS / CLK_NS;
    localparam longint LOCK_WAIT_NS = 64'd1_000_000_000;
    localparam int LOCK_WAIT_CYCLES = int'(LOCK_WAIT_NS / CLK_NS);
    localparam longint LED_ON_NS = 64'd100_000_000;
    localparam int LED_ON_CYCLES = int'(LED_ON_NS / CLK_NS);
    localparam int HB_TIMEOUT_US = 1_600_000;

    // ************************************************************
    // Carriers
    // ************************************************************
    // Special actions of one mapping entry, blink in bit 0
    typedef struct packed {
        logic fifo;
        logic shift0;
        logic shift1;
        logic subsecond_increment_action;
        logic ts_load;
        logic realign;
        logic heartbeat;
        logic log_en;
        logic stop_log;
        logic forward;
        logic blink;
    } ecm_act_s;
    localparam int ACT_W = $bits(ecm_act_s);

    // One word of a received or sent data buffer
    typedef struct packed {
        logic [7:0] proto;
        logic [31:0] data;
    } ecm_buf_s;

endpackage : ecm_pkg

//--- ecm_map_ram.sv
// Mapping memory indexed by event code, registered read
`timescale 1ns/100ps
module ecm_map_ram import ecm_pkg::*; #(
    parameter int W = 41
) (
    input wire logic pclk,
    input wire logic [7:0] rd_addr,
    output logic [W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [W-1:0] wr_data
);
    logic [W-1:0] mem [0:255];

    // One write port from software, one read port from the link
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : ecm_map_ram

//--- ecm_event_log.sv
// Circular event log with freeze and software read port
`timescale 1ns/100ps
module ecm_event_log import ecm_pkg::*; #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    input wire logic frozen,
    input wire logic [AW-1:0] rd_idx,
    output logic [31:0] rd_data,
    output logic [AW-1:0] wr_ptr
);
    logic [31:0] mem [0:DEPTH-1];
    wire do_write = wr_en & ~frozen;

    // Store and advance unless frozen, wrapping around
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
        end else if (do_write) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge pclk) begin
        if (do_write) begin
            mem[wr_ptr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_idx];
endmodule : ecm_event_log

//--- ecm_mapper.sv
// Event code action mapper with APB register access
`timescale 1ns/100ps
module ecm_mapper import ecm_pkg::*; #(
    parameter int NPUL = 10,
    parameter int NCONS = 4,
    parameter int LOG_DEPTH = 16,
    parameter int LOG_AW = 4,
    parameter int LED_CYCLES = LED_ON_CYCLES,
    parameter int LOCK_CYCLES = LOCK_WAIT_CYCLES,
    parameter int HB_TIMEOUT = HB_TIMEOUT_US
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] rx_code,
    input wire ecm_buf_s rx_buf,
    input wire logic rx_buf_valid,
    input wire ecm_buf_s tx_buf_in,
    input wire logic tx_buf_in_valid,
    input wire logic osc_locked,
    output logic [NPUL-1:0] pul_trig,
    output logic [NPUL-1:0] pul_set,
    output logic [NPUL-1:0] pul_rst,
    output logic led_on,
    output logic [7:0] tx_code,
    output logic fifo_force,
    output logic [7:0] fifo_code,
    output logic ps_realign,
    output logic log_freeze_irq,
    output logic [NCONS-1:0] cons_valid,
    output ecm_buf_s cons_buf,
    output ecm_buf_s tx_buf,
    output logic tx_buf_valid,
    output logic outputs_unstable
);
    localparam int ENT_W = ACT_W + 3 * NPUL;

    // ************************************************************
    // Register bus decode
    // ************************************************************
    logic buf_mode, ts_mapped, log_frozen, hb_timeout, lock_fault;
    logic [7:0] map_code;
    ecm_act_s map_spc;
    logic [NPUL-1:0] map_trg, map_set, map_rst;
    logic [31:0] seconds, subsec, shift_reg;
    logic [LOG_AW-1:0] log_idx;
    logic [NCONS-1:0][7:0] cons_proto;
    logic [31:0] log_rd;
    logic [31:0] rd_mux;

    wire setup_ph = psel & ~penable;
    wire wr_acc = psel & penable & pwrite;
    wire [ADDR_W-1:0] cons_off = paddr - REG_CONS_BASE;
    wire cons_sel = (paddr >= REG_CONS_BASE) && (cons_off < ADDR_W'(4 * NCONS)) && (paddr[1:0] == 2'b00);
    wire [ADDR_W-3:0] cons_idx = cons_off[ADDR_W-1:2];
    wire hit_ctrl = paddr == REG_CTRL;
    wire hit_mcode = paddr == REG_MAP_CODE;
    wire known = hit_ctrl | hit_mcode | cons_sel | (paddr == REG_STATUS) | (paddr == REG_MAP_SPC)
        | (paddr == REG_MAP_TRG) | (paddr == REG_MAP_SET) | (paddr == REG_MAP_RST)
        | (paddr == REG_SECONDS) | (paddr == REG_SUBSEC) | (paddr == REG_SHIFT)
        | (paddr == REG_LOG_IDX) | (paddr == REG_LOG_DATA);
    wire map_commit = wr_acc & hit_mcode & pwdata[MAP_COMMIT_BIT];
    wire log_clear = wr_acc & hit_ctrl & pwdata[CTRL_LOG_CLEAR];
    wire [31:0] status_word = {27'h0, outputs_unstable, hb_timeout, lock_fault, osc_locked, log_frozen};

    // Read data selection, unmapped reads give zero
    assign rd_mux = hit_ctrl ? {30'h0, ts_mapped, buf_mode}
        : (paddr == REG_STATUS) ? status_word
        : hit_mcode ? {24'h0, map_code}
        : (paddr == REG_MAP_SPC) ? 32'(map_spc)
        : (paddr == REG_MAP_TRG) ? 32'(map_trg)
        : (paddr == REG_MAP_SET) ? 32'(map_set)
        : (paddr == REG_MAP_RST) ? 32'(map_rst)
        : (paddr == REG_SECONDS) ? seconds
        : (paddr == REG_SUBSEC) ? subsec
        : (paddr == REG_SHIFT) ? shift_reg
        : (paddr == REG_LOG_IDX) ? 32'(log_idx)
        : (paddr == REG_LOG_DATA) ? log_rd
        : cons_sel ? {24'h0, cons_proto[cons_idx]}
        : ZERO_WORD;

    // Read data captured in setup, answer in the first access cycle
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~known;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= ZERO_WORD;
        end else if (setup_ph) begin
            prdata <= rd_mux;
        end
    end

    // Software writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_mode <= 1'b0;
            ts_mapped <= 1'b0;
            map_code <= NO_CODE;
            map_spc <= '0;
            map_trg <= '0;
            map_set <= '0;
            map_rst <= '0;
            log_idx <= '0;
        end else if (wr_acc) begin
            if (hit_ctrl) begin
                buf_mode <= pwdata[CTRL_BUF_MODE];
                ts_mapped <= pwdata[CTRL_TS_MAPPED];
            end
            if (hit_mcode) map_code <= pwdata[7:0];
            if (paddr == REG_MAP_SPC) map_spc <= pwdata[ACT_W-1:0];
            if (paddr == REG_MAP_TRG) map_trg <= pwdata[NPUL-1:0];
            if (paddr == REG_MAP_SET) map_set <= pwdata[NPUL-1:0];
            if (paddr == REG_MAP_RST) map_rst <= pwdata[NPUL-1:0];
            if (paddr == REG_LOG_IDX) log_idx <= pwdata[LOG_AW-1:0];
        end
    end

    // ************************************************************
    // Mapping memory and action decode
    // ************************************************************
    logic [ENT_W-1:0] ent;
    logic [7:0] code_q;
    logic code_vld_q;

    ecm_map_ram #(.W(ENT_W)) u_map (
        .pclk(pclk),
        .rd_addr(rx_code),
        .rd_data(ent),
        .wr_en(map_commit),
        .wr_addr(map_code),
        .wr_data({map_rst, map_set, map_trg, map_spc})
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_q <= NO_CODE;
            code_vld_q <= 1'b0;
        end else begin
            code_q <= rx_code;
            code_vld_q <= rx_code != NO_CODE;
        end
    end

    wire ecm_act_s act = code_vld_q ? ecm_act_s'(ent[ACT_W-1:0]) : '0;
    wire [NPUL-1:0] ent_trg = code_vld_q ? ent[ACT_W +: NPUL] : '0;
    wire [NPUL-1:0] ent_set = code_vld_q ? ent[ACT_W + NPUL +: NPUL] : '0;
    wire [NPUL-1:0] ent_rst = code_vld_q ? ent[ACT_W + 2 * NPUL +: NPUL] : '0;

    // ************************************************************
    // Per-code outputs
    // ************************************************************
    // pulse unit functions, forward, realign, forced FIFO
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pul_trig <= '0;
            pul_set <= '0;
            pul_rst <= '0;
            tx_code <= NO_CODE;
            ps_realign <= 1'b0;
            fifo_force <= 1'b0;
            fifo_code <= NO_CODE;
        end else begin
            pul_trig <= ent_trg;
            pul_set <= ent_set;
            pul_rst <= ent_rst;
            tx_code <= act.forward ? code_q : NO_CODE;
            ps_realign <= act.realign;
            fifo_force <= act.fifo;
            fifo_code <= act.fifo ? code_q : NO_CODE;
        end
    end

    logic [31:0] led_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_cnt <= ZERO_WORD;
        end else if (act.blink) begin
            led_cnt <= 32'(LED_CYCLES);
        end else if (led_cnt != ZERO_WORD) begin
            led_cnt <= led_cnt - 1'b1;
        end
    end
    assign led_on = led_cnt != ZERO_WORD;

    // ************************************************************
    // Event log
    // ************************************************************
    // freeze, set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_frozen <= 1'b0;
        end else if (act.stop_log) begin
            log_frozen <= 1'b1;
        end else if (log_clear) begin
            log_frozen <= 1'b0;
        end
    end
    assign log_freeze_irq = log_frozen;

    // only log-mapped codes stored, with sub-second stamp
    ecm_event_log #(.DEPTH(LOG_DEPTH), .AW(LOG_AW)) u_log (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(act.log_en),
        .wr_data({subsec[LOG_SUB_W-1:0], code_q}),
        .frozen(log_frozen),
        .rd_idx(log_idx),
        .rd_data(log_rd),
        .wr_ptr()
    );

    // ************************************************************
    // Heartbeat timer
    // ************************************************************
    logic [15:0] hb_pre;
    logic [31:0] hb_us;
    wire hb_tick = hb_pre == 16'(HB_DIV_CYCLES - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hb_pre <= '0;
            hb_us <= ZERO_WORD;
            hb_timeout <= 1'b0;
        end else if (act.heartbeat) begin
            hb_pre <= '0;
            hb_us <= ZERO_WORD;
            hb_timeout <= 1'b0;
        end else begin
            hb_pre <= hb_tick ? '0 : hb_pre + 1'b1;
            if (hb_tick && !hb_timeout) hb_us <= hb_us + 1'b1;
            if (hb_us >= 32'(HB_TIMEOUT)) hb_timeout <= 1'b1;
        end
    end

    // ************************************************************
    // Timestamp
    // ************************************************************
    // load, tick, shift in one or zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seconds <= ZERO_WORD;
            subsec <= ZERO_WORD;
            shift_reg <= ZERO_WORD;
        end else begin
            if (act.ts_load) begin
                seconds <= shift_reg;
                subsec <= ZERO_WORD;
            end else if (act.subsecond_increment_action && ts_mapped) begin
                subsec <= subsec + 1'b1;
            end
            if (act.shift1) shift_reg <= {shift_reg[30:0], 1'b1};
            else if (act.shift0) shift_reg <= {shift_reg[30:0], 1'b0};
        end
    end

    // ************************************************************
    // Data buffers
    // ************************************************************
    // one hit per registered consumer
    logic [NCONS-1:0] next_cons_valid;
    genvar gi;
    for (gi = 0; gi < NCONS; gi++) begin : g_cons
        assign next_cons_valid[gi] = buf_mode & rx_buf_valid & (rx_buf.proto == cons_proto[gi]);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cons_proto[gi] <= NO_CODE;
            end else if (wr_acc && cons_sel && cons_idx == (ADDR_W - 2)'(gi)) begin
                cons_proto[gi] <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cons_valid <= '0;
            cons_buf <= '0;
        end else begin
            cons_valid <= next_cons_valid;
            cons_buf <= rx_buf;
        end
    end

    assign tx_buf_valid = tx_buf_in_valid & buf_mode;
    assign tx_buf = tx_buf_in;

    // ************************************************************
    // Oscillator lock
    // ************************************************************
    logic [31:0] unlock_cnt;
    // fault after long unlock, unstable flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_cnt <= ZERO_WORD;
        end else if (osc_locked) begin
            unlock_cnt <= ZERO_WORD;
        end else if (!lock_fault) begin
            unlock_cnt <= unlock_cnt + 1'b1;
        end
    end
    assign lock_fault = unlock_cnt >= 32'(LOCK_CYCLES);
    assign outputs_unstable = ~osc_locked;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_fwd_code: assert property (@(posedge pclk) disable iff (!presetn)
        act.forward |=> tx_code == $past(code_q)) else $error("Forwarded code wrong");
    a_zero_idle: assert property (@(posedge pclk) disable iff (!presetn)
        rx_code == NO_CODE |-> ##2 (pul_trig == '0 && tx_code == NO_CODE)) else $error("Code zero acted");
    a_pulse_trig: assert property (@(posedge pclk) disable iff (!presetn)
        code_vld_q |=> pul_trig == $past(ent[ACT_W +: NPUL])) else $error("Trigger not per map");
    a_stop_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        act.stop_log |=> log_frozen && log_freeze_irq) else $error("Log not frozen");
    a_load_secs: assert property (@(posedge pclk) disable iff (!presetn)
        act.ts_load |=> seconds == $past(shift_reg) && subsec == ZERO_WORD) else $error("Load failed");
    a_tick_inc: assert property (@(posedge pclk) disable iff (!presetn)
        act.subsecond_increment_action && ts_mapped && !act.ts_load |=> subsec == $past(subsec) + 1) else $error("Tick missed");
    a_shift_one: assert property (@(posedge pclk) disable iff (!presetn)
        act.shift1 |=> shift_reg == {$past(shift_reg[30:0]), 1'b1}) else $error("Shift in one wrong");
    a_buf_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !buf_mode |=> cons_valid == '0) else $error("Buffer taken in bus-only mode");
    a_tx_gate: assert property (@(posedge pclk) disable iff (!presetn)
        tx_buf_valid |-> buf_mode) else $error("Buffer sent in bus-only mode");
    a_lock_flag: assert property (@(posedge pclk) disable iff (!presetn)
        outputs_unstable != osc_locked) else $error("Unstable flag wrong");
endmodule : ecm_mapper

//--- ecm_evgen_model.sv
// Upstream event generator model driving codes and buffer words
`timescale 1ns/100ps
module ecm_evgen_model import ecm_pkg::*; (
    input wire logic pclk,
    output logic [7:0] rx_code,
    output ecm_buf_s rx_buf,
    output logic rx_buf_valid
);
    // ************************************************************
    // Link traffic
    // ************************************************************
    // idle no event
    initial begin
        rx_code = NO_CODE;
        rx_buf = '0;
        rx_buf_valid = 1'b0;
    end

    task automatic send_code(input logic [7:0] c);
        @(posedge pclk);
        rx_code <= c;
        @(posedge pclk);
        rx_code <= NO_CODE;
    endtask : send_code

    // One word; a released word shows its inverse
    task automatic send_buf(input logic [7:0] p, input logic [31:0] d);
        @(posedge pclk);
        rx_buf <= '{proto: p, data: d};
        rx_buf_valid <= 1'b1;
        @(posedge pclk);
        rx_buf <= ~rx_buf;
        rx_buf_valid <= 1'b0;
    endtask : send_buf
endmodule : ecm_evgen_model

//--- ecm_mapper_tb.sv
// Self-checking testbench of the event code action mapper
`timescale 1ns/100ps
module ecm_mapper_tb import ecm_pkg::*; ;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, osc_locked, tx_buf_in_valid;
    logic rx_buf_valid, tx_buf_valid, led_on, fifo_force, ps_realign, log_freeze_irq, outputs_unstable;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] rx_code, tx_code, fifo_code;
    logic [9:0] pul_trig, pul_set, pul_rst;
    logic [3:0] cons_valid;
    logic [7:0] prot [4] = '{8'h11, 8'h22, 8'h11, 8'h33};
    ecm_buf_s rx_buf, cons_buf, tx_buf_in, tx_buf;
    int miscompares = 0;
    int n_tests = 0;
    // Event side outputs gathered for one comparison
    wire logic [63:0] obs = {14'h0, log_freeze_irq, led_on, tx_code, fifo_force, fifo_code, ps_realign,
        pul_trig, pul_set, pul_rst};

    // Clock of 4 ns
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    ecm_mapper #(.LED_CYCLES(4), .LOCK_CYCLES(20), .HB_TIMEOUT(3)) ecm_mapper_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_code(rx_code),
        .rx_buf(rx_buf), .rx_buf_valid(rx_buf_valid), .tx_buf_in(tx_buf_in),
        .tx_buf_in_valid(tx_buf_in_valid), .osc_locked(osc_locked), .pul_trig(pul_trig),
        .pul_set(pul_set), .pul_rst(pul_rst), .led_on(led_on), .tx_code(tx_code),
        .fifo_force(fifo_force), .fifo_code(fifo_code), .ps_realign(ps_realign),
        .log_freeze_irq(log_freeze_irq), .cons_valid(cons_valid), .cons_buf(cons_buf),
        .tx_buf(tx_buf), .tx_buf_valid(tx_buf_valid), .outputs_unstable(outputs_unstable)
    );
    ecm_evgen_model ecm_evgen_model_inst (
        .pclk(pclk), .rx_code(rx_code), .rx_buf(rx_buf), .rx_buf_valid(rx_buf_valid)
    );

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [63:0] ex(logic fz, logic led, logic [7:0] tx, logic ff, logic [7:0] fc,
        logic ps, logic [9:0] t, logic [9:0] s, logic [9:0] r);
        return {14'h0, fz, led, tx, ff, fc, ps, t, s, r};
    endfunction : ex

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, ZERO_WORD);
        chk(64'(rd & m), 64'(e), "read");
    endtask : rdchk

    task automatic logchk(input logic [31:0] i, input logic [31:0] e);
        apb(1'b1, REG_LOG_IDX, i);
        repeat (2) @(posedge pclk);
        rdchk(REG_LOG_DATA, 32'hffff_ffff, e);
    endtask : logchk

    // Stage a mapping entry and commit it to the code
    task automatic map(input logic [7:0] c, input logic [10:0] s, input logic [9:0] t,
        input logic [9:0] st, input logic [9:0] r);
        apb(1'b1, REG_MAP_SPC, {21'h0, s});
        apb(1'b1, REG_MAP_TRG, {22'h0, t});
        apb(1'b1, REG_MAP_SET, {22'h0, st});
        apb(1'b1, REG_MAP_RST, {22'h0, r});
        apb(1'b1, REG_MAP_CODE, {24'h0, c});
        apb(1'b1, REG_MAP_CODE, {23'h0, 1'b1, c});
    endtask : map

    // Send one code and look at its one-cycle actions on the edge after the code is taken
    task automatic ev(input logic [7:0] c, input logic [63:0] e);
        ecm_evgen_model_inst.send_code(c);
        @(posedge pclk);
        #1;
        chk(obs, e, "actions");
    endtask : ev

    task automatic bufchk(input logic [7:0] p, input logic [31:0] d, input logic [3:0] m);
        logic [3:0] s;
        ecm_buf_s cb;
        s = 4'h0;
        cb = '0;
        ecm_evgen_model_inst.send_buf(p, d);
        repeat (2) begin
            #1;
            s = s | cons_valid;
            if (cons_valid !== 4'h0) cb = cons_buf;
            @(posedge pclk);
        end
        chk(64'(s), 64'(m), "consumers");
        if (m !== 4'h0) chk(64'(cb), {24'h0, p, d}, "buffer copy");
    endtask : bufchk

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = ZERO_WORD;
        osc_locked = 1'b1;
        tx_buf_in = '{proto: 8'h44, data: 32'h1234_5678};
        tx_buf_in_valid = 1'b1;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(REG_CTRL, 32'hffff_ffff, ZERO_WORD);
        rdchk(REG_STATUS, 32'h0000_001f, 32'h0000_0002);
        apb(1'b0, 12'h030, ZERO_WORD);
        chk(64'({rd, err}), 64'h1, "unmapped");
        $display("test registers done");
        map(8'h00, 11'h403, 10'h3ff, '0, '0);
        map(8'h05, '0, 10'h009, '0, '0);
        map(8'h06, '0, '0, 10'h008, 10'h001);
        map(8'h0e, 11'h001, '0, '0, '0);
        map(8'h09, 11'h422, '0, '0, '0);
        ev(8'h00, 64'h0);
        ev(8'h05, ex('0, '0, '0, '0, '0, '0, 10'h009, '0, '0));
        ev(8'h06, ex('0, '0, '0, '0, '0, '0, '0, 10'h008, 10'h001));
        ev(8'h0e, ex('0, 1'b1, '0, '0, '0, '0, '0, '0, '0));
        repeat (6) @(posedge pclk);
        #1;
        chk(obs, 64'h0, "blink end");
        ev(8'h09, ex('0, '0, 8'h09, 1'b1, 8'h09, 1'b1, '0, '0, '0));
        $display("test actions done");
        map(8'h14, 11'h100, '0, '0, '0);
        map(8'h15, 11'h200, '0, '0, '0);
        map(8'h16, 11'h040, '0, '0, '0);
        map(8'h17, 11'h080, '0, '0, '0);
        ev(8'h14, 64'h0);
        ev(8'h15, 64'h0);
        ev(8'h14, 64'h0);
        rdchk(REG_SHIFT, 32'hffff_ffff, 32'h0000_0005);
        apb(1'b1, REG_CTRL, 32'h0000_0002);
        ev(8'h16, 64'h0);
        rdchk(REG_SECONDS, 32'hffff_ffff, 32'h0000_0005);
        rdchk(REG_SUBSEC, 32'hffff_ffff, ZERO_WORD);
        repeat (3) ev(8'h17, 64'h0);
        rdchk(REG_SUBSEC, 32'hffff_ffff, 32'h0000_0003);
        $display("test timestamp done");
        map(8'h1e, 11'h008, '0, '0, '0);
        map(8'h1f, '0, '0, '0, '0);
        map(8'h21, 11'h008, '0, '0, '0);
        map(8'h20, 11'h004, '0, '0, '0);
        ev(8'h1e, 64'h0);
        ev(8'h1f, 64'h0);
        ev(8'h21, 64'h0);
        logchk(ZERO_WORD, 32'h0000_031e);
        logchk(32'h0000_0001, 32'h0000_0321);
        ev(8'h20, ex(1'b1, '0, '0, '0, '0, '0, '0, '0, '0));
        rdchk(REG_STATUS, 32'h0000_0001, 32'h0000_0001);
        apb(1'b1, REG_CTRL, 32'h0000_0006);
        rdchk(REG_STATUS, 32'h0000_0001, ZERO_WORD);
        $display("test log done");
        map(8'h28, 11'h010, '0, '0, '0);
        repeat (1000) @(posedge pclk);
        rdchk(REG_STATUS, 32'h0000_0008, 32'h0000_0008);
        ev(8'h28, 64'h0);
        rdchk(REG_STATUS, 32'h0000_0008, ZERO_WORD);
        repeat (1000) @(posedge pclk);
        rdchk(REG_STATUS, 32'h0000_0008, 32'h0000_0008);
        osc_locked <= 1'b0;
        @(posedge pclk);
        #1;
        chk(64'(outputs_unstable), 64'h1, "unstable");
        rdchk(REG_STATUS, 32'h0000_0016, 32'h0000_0010);
        repeat (25) @(posedge pclk);
        rdchk(REG_STATUS, 32'h0000_0004, 32'h0000_0004);
        osc_locked <= 1'b1;
        repeat (3) @(posedge pclk);
        rdchk(REG_STATUS, 32'h0000_0012, 32'h0000_0002);
        $display("test heartbeat and lock done");
        for (int i = 0; i < 4; i++) apb(1'b1, REG_CONS_BASE + 12'(4 * i), {24'h0, prot[i]});
        bufchk(8'h11, 32'hcafe_0001, 4'h0);
        chk(64'(tx_buf_valid), 64'h0, "tx off");
        apb(1'b1, REG_CTRL, 32'h0000_0003);
        bufchk(8'h11, 32'hcafe_0002, 4'h5);
        bufchk(8'h33, 32'hcafe_0003, 4'h8);
        bufchk(8'h55, 32'hcafe_0004, 4'h0);
        chk(64'({tx_buf_valid, tx_buf}), {23'h0, 1'b1, 8'h44, 32'h1234_5678}, "tx on");
        $display("test buffers done");
        results();
    end

    // Watchdog against a hung run
    initial begin
        #200000;
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end
endmodule : ecm_mapper_tb
